// ===== s2sp_pkg.sv
package s2sp_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam int         ADDR_W   = 10;
  localparam logic [7:0] IX_SADDR = 8'haa;
  localparam logic [7:0] IX_MASK  = 8'hba;
  localparam logic [7:0] IX_CTRL  = 8'hc0;
  localparam logic [7:0] IX_BUF   = 8'hc1;
  localparam logic [7:0] IX_CDIV  = 8'hc4;
  localparam logic [7:0] IX_STAT  = 8'hc5;
  localparam logic [7:0] IX_PWR   = 8'he8;
  localparam logic [7:0] IX_EVT   = 8'hf0;
  localparam logic [7:0] IX_EMSK  = 8'hf1;
  localparam logic [7:0] IX_BAUD  = 8'hf2;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CT_MHI = 7;
  localparam int CT_MLO = 6;
  localparam int CT_MP  = 5;
  localparam int CT_REN = 4;
  localparam int CT_TB8 = 3;
  localparam int CT_RB8 = 2;
  localparam int CT_TI  = 1;
  localparam int CT_RI  = 0;
  localparam int CD_HI  = 7;
  localparam int CD_LO  = 6;
  localparam int CD_SWB = 5;
  localparam int ST_TXA = 3;
  localparam int ST_RXA = 2;
  localparam int PW_DBL = 7;
  localparam int PW_FES = 6;
  localparam int EV_RX  = 0;
  localparam int EV_TX  = 1;
  localparam int EV_FE  = 2;
  localparam logic [1:0] CD_DIV4  = 2'h1;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] EV_RST   = 3'h0;

  // ****************************************************************
  // Modes and timing
  // ****************************************************************
  localparam logic [1:0] MD_SYNC = 2'h0;
  localparam logic [1:0] MD_A10  = 2'h1;
  localparam logic [1:0] MD_F11  = 2'h2;
  localparam logic [1:0] MD_V11  = 2'h3;
  localparam int CNT_W     = 13;
  localparam int SYNC_SLOW = 12;
  localparam int SYNC_FAST = 4;
  localparam int FIX_SLOW  = 64;
  localparam int FIX_FAST  = 32;
  localparam int BAUD_UNIT = 16;
  localparam logic [3:0] BITS_SYNC = 4'h8;
  localparam logic [3:0] BITS_A10  = 4'ha;
  localparam logic [3:0] BITS_A11  = 4'hb;
  localparam logic [3:0] RXB_A10   = 4'h9;
  localparam logic [3:0] RXB_A11   = 4'ha;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b100
  } s2sp_rx_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } s2sp_tx_type;

endpackage : s2sp_pkg

// ===== s2sp_remote.sv
`timescale 1ns/1ps
`default_nettype none
module s2sp_remote (
  input  wire logic mclk,
  input  wire logic txd,
  output var  logic lineOut
);
  // The line rests at mark level between frames, as an idle node leaves it.
  initial lineOut = 1'b1;

  task automatic sendFrame(input logic [10:0] bits, input int n, input int bt);
    for (int i = 0; i < n; i++) begin
      lineOut <= bits[i];
      repeat (bt) @(posedge mclk);
    end
    lineOut <= 1'b1;
  endtask : sendFrame

  // Samples each bit at its middle, so a half-cycle skew cannot flip a bit.
  task automatic catchFrame(input int n, input int bt, output logic [10:0] bits);
    bits = 11'h000;
    @(negedge txd);
    repeat (bt / 2) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      repeat (bt) @(posedge mclk);
    end
  endtask : catchFrame
endmodule : s2sp_remote
`default_nettype wire

// ===== s2sp_uart.sv
// Overview of operation
// - Bit seven is mode bit or framing flag
// - Two mode bits pick one of four modes
// - Nine-bit modes with MP set drop frames with ninth bit zero
// - Ten-bit mode with MP set drops frames with bad stop
// - Sync shift clock divides by twelve or four
// - Reception starts only while receive enable set
// - Nine-bit modes send software ninth bit
// - Received ninth bit holds ninth or stop
// - Transmit flag set at stop start, software clears
// - Receive flag set mid stop, software clears
// - Buffer read gives receive, write starts send
// - Mask ones select compared address bits
// - All-zero mask accepts any address byte
// - Transmit activity until transmit flag sets
// - Receive activity until last bit sampled
// - Divide writes ignored while active with switchback
// - Switchback forces divide-by-four on activity
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module s2sp_uart (
  input  wire logic [s2sp_pkg::ADDR_W-1:0] address,
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [31:0]                 writedata,
  output var  logic [31:0]                 readdata,
  output var  logic                        waitrequest,
  output var  logic                        irq,
  input  wire logic                        rxdIn,
  output var  logic                        rxdOut,
  output var  logic                        rxdOeB,
  output var  logic                        txd
);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  function automatic logic hit(input logic [7:0] idx);
    hit = (address == {idx, 2'b00});
  endfunction : hit

  logic       wr;
  logic [7:0] wd;
  logic [7:0] rdMux;
  assign wr = write & ~waitrequest;
  assign wd = writedata[7:0];

  // One wait cycle gives the read mux a full cycle before the answer.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
    end else if ((read | write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= 32'h0;
    end else if (read && waitrequest) begin
      readdata <= {24'h0, rdMux};
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic       modeHi_q, modeLo_q, mp_q, ren_q, tb8_q, rb8_q, ti_q, ri_q;
  logic       frameErr_q, swb_q, feSel_q, dbl_q, txAct_q, rxAct_q;
  logic [1:0] cd_q;
  logic [2:0] evt_q, evtMask_q;
  logic [7:0] mask_q, slvAddr_q, baud_q, rxData_q;
  logic [1:0] mode;
  logic       txDone, rxEnd, rxTake, feEv, txGo, rxBegin;
  logic [7:0] rxByte;
  logic       rxNinth, rxStop;
  assign mode = {modeHi_q, modeLo_q};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mask_q    <= s2sp_pkg::BYTE_RST;
      slvAddr_q <= s2sp_pkg::BYTE_RST;
      baud_q    <= s2sp_pkg::BYTE_RST;
      dbl_q     <= 1'b0;
      feSel_q   <= 1'b0;
      evtMask_q <= s2sp_pkg::EV_RST;
    end else begin
      if (wr && hit(s2sp_pkg::IX_MASK)) begin
        mask_q <= wd;
      end
      if (wr && hit(s2sp_pkg::IX_SADDR)) begin
        slvAddr_q <= wd;
      end
      if (wr && hit(s2sp_pkg::IX_BAUD)) begin
        baud_q <= wd;
      end
      if (wr && hit(s2sp_pkg::IX_PWR)) begin
        dbl_q   <= wd[s2sp_pkg::PW_DBL];
        feSel_q <= wd[s2sp_pkg::PW_FES];
      end
      if (wr && hit(s2sp_pkg::IX_EMSK)) begin
        evtMask_q <= wd[2:0];
      end
    end
  end

  // Hardware set beats a same-cycle software write on every flag.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      modeHi_q   <= 1'b0;
      modeLo_q   <= 1'b0;
      mp_q       <= 1'b0;
      ren_q      <= 1'b0;
      tb8_q      <= 1'b0;
      rb8_q      <= 1'b0;
      ti_q       <= 1'b0;
      ri_q       <= 1'b0;
      frameErr_q <= 1'b0;
    end else begin
      if (wr && hit(s2sp_pkg::IX_CTRL)) begin
        if (feSel_q) begin
          frameErr_q <= wd[s2sp_pkg::CT_MHI];
        end else begin
          modeHi_q <= wd[s2sp_pkg::CT_MHI];
        end
        modeLo_q <= wd[s2sp_pkg::CT_MLO];
        mp_q     <= wd[s2sp_pkg::CT_MP];
        ren_q    <= wd[s2sp_pkg::CT_REN];
        tb8_q    <= wd[s2sp_pkg::CT_TB8];
        rb8_q    <= wd[s2sp_pkg::CT_RB8];
        ti_q     <= wd[s2sp_pkg::CT_TI];
        ri_q     <= wd[s2sp_pkg::CT_RI];
      end
      if (feEv) begin
        frameErr_q <= 1'b1;
      end
      if (txDone) begin
        ti_q <= 1'b1;
      end
      if (rxTake) begin
        ri_q <= 1'b1;
        if (mode != s2sp_pkg::MD_SYNC) begin
          rb8_q <= (mode == s2sp_pkg::MD_A10) ? rxStop : rxNinth;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxData_q <= s2sp_pkg::BYTE_RST;
    end else if (rxTake) begin
      rxData_q <= rxByte;
    end
  end

  // ****************************************************************
  // Clock divide with switchback
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cd_q  <= s2sp_pkg::CD_DIV4;
      swb_q <= 1'b0;
    end else begin
      if (wr && hit(s2sp_pkg::IX_CDIV)) begin
        swb_q <= wd[s2sp_pkg::CD_SWB];
        if (!(swb_q && (txAct_q || rxAct_q))) begin
          cd_q <= wd[s2sp_pkg::CD_HI:s2sp_pkg::CD_LO];
        end
      end
      if (swb_q && (txGo || rxBegin)) begin
        cd_q <= s2sp_pkg::CD_DIV4;
      end
    end
  end

  // ****************************************************************
  // Bit timing
  // ****************************************************************
  function automatic logic [s2sp_pkg::CNT_W-1:0] bitLen(
    input logic [1:0] md, input logic fast, input logic dbl,
    input logic [7:0] bd);
    unique case (md)
      s2sp_pkg::MD_SYNC: bitLen = s2sp_pkg::CNT_W'(fast ? s2sp_pkg::SYNC_FAST
                                                        : s2sp_pkg::SYNC_SLOW);
      s2sp_pkg::MD_F11:  bitLen = s2sp_pkg::CNT_W'(dbl ? s2sp_pkg::FIX_FAST
                                                       : s2sp_pkg::FIX_SLOW);
      default: bitLen = s2sp_pkg::CNT_W'((int'(bd) + 1) * s2sp_pkg::BAUD_UNIT);
    endcase
  endfunction : bitLen

  logic [s2sp_pkg::CNT_W-1:0] bitMax, bitHalf;
  assign bitMax  = bitLen(mode, mp_q, dbl_q, baud_q) - 1'b1;
  assign bitHalf = bitMax >> 1;

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  s2sp_pkg::s2sp_tx_type      txState_q;
  logic [s2sp_pkg::CNT_W-1:0] txCnt_q;
  logic [10:0]                txShift_q;
  logic [3:0]                 txLeft_q;
  logic                       txEnd;

  assign txGo  = wr && hit(s2sp_pkg::IX_BUF);
  assign txEnd = (txState_q == s2sp_pkg::TX_SEND) && (txCnt_q == '0);
  assign txDone = txEnd && (txLeft_q == ((mode == s2sp_pkg::MD_SYNC) ? 4'h1
                                                                     : 4'h2));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txState_q <= s2sp_pkg::TX_IDLE;
      txCnt_q   <= '0;
      txShift_q <= '1;
      txLeft_q  <= '0;
    end else if (txGo) begin
      txState_q <= s2sp_pkg::TX_SEND;
      txCnt_q   <= bitMax;
      unique case (mode)
        s2sp_pkg::MD_SYNC: begin
          txShift_q <= {3'b111, wd};
          txLeft_q  <= s2sp_pkg::BITS_SYNC;
        end
        s2sp_pkg::MD_A10: begin
          txShift_q <= {2'b11, wd, 1'b0};
          txLeft_q  <= s2sp_pkg::BITS_A10;
        end
        default: begin
          txShift_q <= {1'b1, tb8_q, wd, 1'b0};
          txLeft_q  <= s2sp_pkg::BITS_A11;
        end
      endcase
    end else if (txEnd) begin
      txCnt_q   <= bitMax;
      txShift_q <= {1'b1, txShift_q[10:1]};
      txLeft_q  <= txLeft_q - 1'b1;
      if (txLeft_q == 4'h1) begin
        txState_q <= s2sp_pkg::TX_IDLE;
      end
    end else if (txState_q == s2sp_pkg::TX_SEND) begin
      txCnt_q <= txCnt_q - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txAct_q <= 1'b0;
    end else if (txGo) begin
      // A buffer write restarts the frame, so it outranks the end of the old one.
      txAct_q <= 1'b1;
    end else if (txDone) begin
      txAct_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  s2sp_pkg::s2sp_rx_type      rxState_q;
  logic [s2sp_pkg::CNT_W-1:0] rxCnt_q;
  logic [9:0]                 rxShift_q, rxNext;
  logic [3:0]                 rxLeft_q;
  logic                       rxdPrev_q, addrOk, rxDataEnd;

  assign rxNext    = {rxdIn, rxShift_q[9:1]};
  assign rxDataEnd = (rxState_q == s2sp_pkg::RX_DATA) && (rxCnt_q == '0);
  assign rxEnd     = rxDataEnd && (rxLeft_q == 4'h1);
  // Sync reception waits for an idle transmitter: both use the pins.
  assign rxBegin = (rxState_q == s2sp_pkg::RX_IDLE) && ren_q &&
                   ((mode == s2sp_pkg::MD_SYNC) ? (!ri_q && !txAct_q)
                                                : (rxdPrev_q && !rxdIn));
  assign rxStop  = rxNext[9];
  assign rxNinth = rxNext[8];

  always_comb begin
    unique case (mode)
      s2sp_pkg::MD_SYNC: rxByte = rxNext[9:2];
      s2sp_pkg::MD_A10:  rxByte = rxNext[8:1];
      default:           rxByte = rxNext[7:0];
    endcase
  end

  // A zero mask leaves nothing to compare, so any address passes.
  assign addrOk = ((rxByte ^ slvAddr_q) & mask_q) == 8'h00;

  always_comb begin
    unique case (mode)
      s2sp_pkg::MD_SYNC: rxTake = rxEnd;
      s2sp_pkg::MD_A10:  rxTake = rxEnd && (!mp_q || rxStop);
      default:           rxTake = rxEnd && (!mp_q || (rxNinth && addrOk));
    endcase
  end

  assign feEv = rxEnd && (mode != s2sp_pkg::MD_SYNC) && !rxStop;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxdPrev_q <= 1'b1;
    end else begin
      rxdPrev_q <= rxdIn;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxState_q <= s2sp_pkg::RX_IDLE;
      rxCnt_q   <= '0;
      rxShift_q <= '0;
      rxLeft_q  <= '0;
    end else begin
      unique case (rxState_q)
        s2sp_pkg::RX_IDLE: begin
          if (rxBegin && mode == s2sp_pkg::MD_SYNC) begin
            rxState_q <= s2sp_pkg::RX_DATA;
            rxCnt_q   <= bitMax;
            rxLeft_q  <= s2sp_pkg::BITS_SYNC;
          end else if (rxBegin) begin
            rxState_q <= s2sp_pkg::RX_START;
            rxCnt_q   <= bitHalf;
          end
        end
        s2sp_pkg::RX_START: begin
          if (rxCnt_q != '0) begin
            rxCnt_q <= rxCnt_q - 1'b1;
          end else if (rxdIn) begin
            rxState_q <= s2sp_pkg::RX_IDLE; // Glitch, not a start bit.
          end else begin
            rxState_q <= s2sp_pkg::RX_DATA;
            rxCnt_q   <= bitMax;
            rxLeft_q  <= (mode == s2sp_pkg::MD_A10) ? s2sp_pkg::RXB_A10
                                                    : s2sp_pkg::RXB_A11;
          end
        end
        s2sp_pkg::RX_DATA: begin
          if (rxDataEnd) begin
            rxShift_q <= rxNext;
            rxCnt_q   <= bitMax;
            rxLeft_q  <= rxLeft_q - 1'b1;
            if (rxLeft_q == 4'h1) begin
              rxState_q <= s2sp_pkg::RX_IDLE;
            end
          end else begin
            rxCnt_q <= rxCnt_q - 1'b1;
          end
        end
        default: rxState_q <= s2sp_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxAct_q <= 1'b0;
    end else if (rxEnd) begin
      rxAct_q <= 1'b0;
    end else if (rxBegin) begin
      rxAct_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  logic syncTx, syncRx;
  assign syncTx = (mode == s2sp_pkg::MD_SYNC) && (txState_q == s2sp_pkg::TX_SEND);
  assign syncRx = (mode == s2sp_pkg::MD_SYNC) && (rxState_q == s2sp_pkg::RX_DATA);

  // Shift clock is low for the first half of each bit, high for the second.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txd    <= 1'b1;
      rxdOut <= 1'b1;
      rxdOeB <= 1'b1;
    end else begin
      if (syncTx) begin
        txd <= (txCnt_q <= bitHalf);
      end else if (syncRx) begin
        txd <= (rxCnt_q <= bitHalf);
      end else if (mode == s2sp_pkg::MD_SYNC) begin
        txd <= 1'b1;
      end else begin
        txd <= (txState_q == s2sp_pkg::TX_SEND) ? txShift_q[0] : 1'b1;
      end
      rxdOut <= syncTx ? txShift_q[0] : 1'b1;
      rxdOeB <= !syncTx;
    end
  end

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************
  logic [2:0] evtSet;
  assign evtSet = {feEv, txDone, rxTake};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      evt_q <= s2sp_pkg::EV_RST;
    end else if (wr && hit(s2sp_pkg::IX_EVT)) begin
      evt_q <= (evt_q & ~wd[2:0]) | evtSet;
    end else begin
      evt_q <= evt_q | evtSet;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_q & evtMask_q);
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always_comb begin
    rdMux = 8'h00;
    if (hit(s2sp_pkg::IX_MASK)) begin
      rdMux = mask_q;
    end else if (hit(s2sp_pkg::IX_SADDR)) begin
      rdMux = slvAddr_q;
    end else if (hit(s2sp_pkg::IX_CTRL)) begin
      rdMux = {feSel_q ? frameErr_q : modeHi_q, modeLo_q, mp_q, ren_q,
               tb8_q, rb8_q, ti_q, ri_q};
    end else if (hit(s2sp_pkg::IX_BUF)) begin
      rdMux = rxData_q;
    end else if (hit(s2sp_pkg::IX_CDIV)) begin
      rdMux = {cd_q, swb_q, 5'h00};
    end else if (hit(s2sp_pkg::IX_STAT)) begin
      rdMux[s2sp_pkg::ST_TXA] = txAct_q;
      rdMux[s2sp_pkg::ST_RXA] = rxAct_q;
    end else if (hit(s2sp_pkg::IX_PWR)) begin
      rdMux = {dbl_q, feSel_q, 6'h00};
    end else if (hit(s2sp_pkg::IX_EVT)) begin
      rdMux = {5'h00, evt_q};
    end else if (hit(s2sp_pkg::IX_EMSK)) begin
      rdMux = {5'h00, evtMask_q};
    end else if (hit(s2sp_pkg::IX_BAUD)) begin
      rdMux = baud_q;
    end
  end

endmodule : s2sp_uart
`default_nettype wire

// ===== s2sp_uart_bench.sv
`timescale 1ns/1ps
`default_nettype none
module s2sp_uart_bench;
  localparam int LIMIT = 20000;
  logic [s2sp_pkg::ADDR_W-1:0] address = '0;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest, irq, rxdOut, rxdOeB, txd, remoteLine;
  wire         rxdLine;
  logic [7:0]  rd;
  logic [10:0] frame;
  time         t0;
  int          badCount = 0;
  int          checkCount = 0;
  int          cycles = 0;
  logic [31:0] rows [8] = '{32'hf0f0_530f, 32'hf0f0_630c, 32'hf000_630f, 32'hf000_7704,
                            32'hd0f0_7706, 32'he000_110c, 32'h7000_2200, 32'h5000_2207};

  // The data line is shared: the device drives it only while its enable is low.
  assign rxdLine = rxdOeB ? remoteLine : rxdOut;

  s2sp_uart s2sp_uart_inst (.address(address), .mclk(mclk), .rst_b(rst_b), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .rxdIn(rxdLine), .rxdOut(rxdOut), .rxdOeB(rxdOeB), .txd(txd));
  s2sp_remote s2sp_remote_inst (.mclk(mclk), .txd(txd), .lineOut(remoteLine));

  initial begin
    forever #5 mclk = ~mclk;
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge mclk);
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {24'h000000, wd};
    do @(posedge mclk); while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : access

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    access(1'b0, idx, 8'h00);
    check(32'(rd), 32'(exp));
  endtask : rdChk

  task automatic summarize;
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      badCount++;
      summarize();
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    rdChk(s2sp_pkg::IX_CTRL, 8'h00);
    rdChk(s2sp_pkg::IX_CDIV, 8'h40);
    rdChk(8'h00, 8'h00);
    access(1'b1, s2sp_pkg::IX_MASK, 8'ha5);
    rdChk(s2sp_pkg::IX_MASK, 8'ha5);
    access(1'b1, s2sp_pkg::IX_CDIV, 8'ha0);
    access(1'b1, s2sp_pkg::IX_CTRL, 8'h88);
    access(1'b1, s2sp_pkg::IX_BUF, 8'h3c);
    fork
      s2sp_remote_inst.catchFrame(11, s2sp_pkg::FIX_SLOW, frame);
      begin
        rdChk(s2sp_pkg::IX_STAT, 8'h08);
        rdChk(s2sp_pkg::IX_CDIV, 8'h60);
        access(1'b1, s2sp_pkg::IX_CDIV, 8'he0);
        rdChk(s2sp_pkg::IX_CDIV, 8'h60);
      end
    join
    check(32'(frame), 32'h678);
    rdChk(s2sp_pkg::IX_CTRL, 8'h8a);
    rdChk(s2sp_pkg::IX_STAT, 8'h00);
    access(1'b1, s2sp_pkg::IX_CDIV, 8'ha0);
    rdChk(s2sp_pkg::IX_CDIV, 8'ha0);
    access(1'b1, s2sp_pkg::IX_CDIV, 8'h40);
    for (int mp = 0; mp < 2; mp++) begin
      access(1'b1, s2sp_pkg::IX_CTRL, {2'b00, mp[0], 5'h00});
      access(1'b1, s2sp_pkg::IX_BUF, 8'h81);
      @(negedge txd);
      t0 = $time;
      @(negedge txd);
      check(32'(($time - t0) / 10), mp ? 32'h4 : 32'hc);
      check(32'(rxdOeB), 32'h0);
      @(posedge mclk);
      check(32'(rxdOut), 32'h0);
      repeat (120) @(posedge mclk);
      rdChk(s2sp_pkg::IX_CTRL, {2'b00, mp[0], 5'h02});
    end
    access(1'b1, s2sp_pkg::IX_CTRL, 8'h10);
    repeat (120) @(posedge mclk);
    rdChk(s2sp_pkg::IX_CTRL, 8'h11);
    rdChk(s2sp_pkg::IX_BUF, 8'hff);
    access(1'b1, s2sp_pkg::IX_BAUD, 8'h00);
    access(1'b1, s2sp_pkg::IX_SADDR, 8'h5a);
    access(1'b1, s2sp_pkg::IX_EMSK, 8'h01);
    foreach (rows[i]) begin
      access(1'b1, s2sp_pkg::IX_CTRL, rows[i][31:24]);
      access(1'b1, s2sp_pkg::IX_MASK, rows[i][23:16]);
      frame = rows[i][31] ? {rows[i][2], rows[i][3], rows[i][15:8], 1'b0}
                          : {1'b0, rows[i][2], rows[i][15:8], 1'b0};
      s2sp_remote_inst.sendFrame(frame, rows[i][31] ? 11 : 10, s2sp_pkg::BAUD_UNIT);
      repeat (4) @(posedge mclk);
      access(1'b0, s2sp_pkg::IX_CTRL, 8'h00);
      check(32'(rd[0]), 32'(rows[i][1]));
      if (rows[i][1]) begin
        check(32'(rd[2]), 32'(rows[i][0]));
        rdChk(s2sp_pkg::IX_BUF, rows[i][15:8]);
      end
    end
    check(32'(irq), 32'h1);
    access(1'b1, s2sp_pkg::IX_EMSK, 8'h00);
    repeat (2) @(posedge mclk);
    check(32'(irq), 32'h0);
    access(1'b1, s2sp_pkg::IX_EMSK, 8'h01);
    repeat (2) @(posedge mclk);
    check(32'(irq), 32'h1);
    rdChk(s2sp_pkg::IX_EVT, 8'h07);
    access(1'b1, s2sp_pkg::IX_EVT, 8'h07);
    repeat (2) @(posedge mclk);
    check(32'(irq), 32'h0);
    rdChk(s2sp_pkg::IX_EVT, 8'h00);
    access(1'b1, s2sp_pkg::IX_PWR, 8'h40);
    access(1'b1, s2sp_pkg::IX_CTRL, 8'h50);
    s2sp_remote_inst.sendFrame(11'h044, 10, s2sp_pkg::BAUD_UNIT);
    repeat (4) @(posedge mclk);
    access(1'b0, s2sp_pkg::IX_CTRL, 8'h00);
    check(32'(rd[7]), 32'h1);
    access(1'b1, s2sp_pkg::IX_CTRL, 8'h50);
    access(1'b0, s2sp_pkg::IX_CTRL, 8'h00);
    check(32'(rd[7]), 32'h0);
    summarize();
  end
endmodule : s2sp_uart_bench
`default_nettype wire

// ===== s2sp_uart_chk.sv
`timescale 1ns/1ps
`default_nettype none
module s2sp_uart_chk (
  input wire logic [s2sp_pkg::ADDR_W-1:0] address,
  input wire logic                        mclk,
  input wire logic                        rst_b,
  input wire logic                        read,
  input wire logic                        write,
  input wire logic [31:0]                 writedata,
  input wire logic [31:0]                 readdata,
  input wire logic                        waitrequest,
  input wire logic                        irq,
  input wire logic                        rxdIn,
  input wire logic                        rxdOut,
  input wire logic                        rxdOeB,
  input wire logic                        txd
);
  // ****************************************************************
  // Shadows of software writes
  // ****************************************************************
  logic [7:0] maskShadow_q;
  logic [7:0] emskShadow_q;
  logic [1:0] modeShadow_q;
  logic       wrTaken;
  logic       rdTaken;

  assign wrTaken = write && !waitrequest;
  assign rdTaken = read && !waitrequest;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      maskShadow_q <= 8'h00;
      emskShadow_q <= 8'h00;
      modeShadow_q <= 2'h0;
    end else if (wrTaken) begin
      if (address == {s2sp_pkg::IX_MASK, 2'b00}) maskShadow_q <= writedata[7:0];
      if (address == {s2sp_pkg::IX_EMSK, 2'b00}) emskShadow_q <= writedata[7:0];
      if (address == {s2sp_pkg::IX_CTRL, 2'b00}) modeShadow_q <= writedata[7:6];
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence sReq;
    (read || write) && waitrequest;
  endsequence
  sequence sAns;
    !waitrequest ##1 waitrequest;
  endsequence

  AST_BUS_ANSWER: assert property (sReq |=> sAns)
    else $error("bus answer not one cycle after request");
  AST_NO_SPURIOUS: assert property (!(read || write) && waitrequest |=> waitrequest)
    else $error("bus answer without request");
  AST_UPPER_ZERO: assert property (rdTaken |-> readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  AST_UNMAPPED: assert property (rdTaken && address == 10'h000 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_MASK_READ: assert property (rdTaken && address == {s2sp_pkg::IX_MASK, 2'b00}
    |-> readdata[7:0] == maskShadow_q) else $error("address mask readback wrong");
  AST_BUF_START: assert property (wrTaken && address == {s2sp_pkg::IX_BUF, 2'b00}
    && modeShadow_q != s2sp_pkg::MD_SYNC |=> ##[0:4] !txd) else $error("no start bit");
  AST_OE_ASYNC: assert property (modeShadow_q != s2sp_pkg::MD_SYNC
    && $past(modeShadow_q) != s2sp_pkg::MD_SYNC |-> rxdOeB) else $error("data line driven");
  AST_IRQ_MASKED: assert property (emskShadow_q == 8'h00 && $past(emskShadow_q) == 8'h00
    |-> !irq) else $error("interrupt while fully masked");
  AST_RESET_IDLE: assert property ($rose(rst_b) |-> waitrequest && txd && rxdOut
    && rxdOeB && !irq) else $error("outputs not idle after reset");
endmodule : s2sp_uart_chk

bind s2sp_uart s2sp_uart_chk s2sp_uart_chk_inst (.address(address), .mclk(mclk),
  .rst_b(rst_b), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .irq(irq), .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOeB(rxdOeB),
  .txd(txd));
`default_nettype wire
